// ### common/lsc_pkg.sv
// Purpose: Shared constants for the loop and synthesizer configuration bank.
// Assumes: 8-bit registers, byte offsets as printed, one register clock.
// Notes:   Reset table is indexed by (offset - BASE_OFF).

package lsc_pkg;

    // ==========================================================
    // Map extent
    localparam int NUM_REGS = 39;
    localparam logic [7:0] BASE_OFF = 8'h23;
    localparam logic [7:0] LAST_OFF = 8'h49;
    localparam logic [7:0] UNMAPPED_DATA = 8'h00;

    // ==========================================================
    // Register offsets
    localparam logic [7:0] LOOP1_REV_OFF = 8'h23;
    localparam logic [7:0] LOOP1_PRI0_OFF = 8'h24;
    localparam logic [7:0] LOOP1_PRI1_OFF = 8'h25;
    localparam logic [7:0] LOOP1_PRI2_OFF = 8'h26;
    localparam logic [7:0] LOOP1_PRI3_OFF = 8'h27;
    localparam logic [7:0] LOOP1_LOCK_OFF = 8'h28;
    localparam logic [7:0] KEEP_DEFAULT_OFF = 8'h29;
    localparam logic [7:0] LOOP2_CTRL_A_OFF = 8'h2a;
    localparam logic [7:0] LOOP2_CTRL_B_OFF = 8'h2b;
    localparam logic [7:0] LOOP2_MODE_OFF = 8'h2c;
    localparam logic [7:0] LOOP2_REFSEL_OFF = 8'h2d;
    localparam logic [7:0] LOOP2_FAIL_MASK_OFF = 8'h2e;
    localparam logic [7:0] LOOP2_RESTORE_OFF = 8'h2f;
    localparam logic [7:0] LOOP2_REV_OFF = 8'h30;
    localparam logic [7:0] LOOP2_PRI0_OFF = 8'h31;
    localparam logic [7:0] LOOP2_PRI1_OFF = 8'h32;
    localparam logic [7:0] LOOP2_PRI2_OFF = 8'h33;
    localparam logic [7:0] LOOP2_PRI3_OFF = 8'h34;
    localparam logic [7:0] LOOP2_LOCK_OFF = 8'h35;
    localparam logic [7:0] SA_ENABLE_OFF = 8'h36;
    localparam logic [7:0] SA_RUN_OFF = 8'h37;
    localparam logic [7:0] SA_MULT_LO_OFF = 8'h38;
    localparam logic [7:0] SA_MULT_HI_OFF = 8'h39;
    localparam logic [7:0] SA_CLKA_PHASE_OFF = 8'h3a;
    localparam logic [7:0] SA_CLKB_DIV_OFF = 8'h3b;
    localparam logic [7:0] SA_CLKB_PHASE_OFF = 8'h3c;
    localparam logic [7:0] SA_FINE_OFF = 8'h3d;
    localparam logic [7:0] SA_PA_RATE_OFF = 8'h3e;
    localparam logic [7:0] SA_PA_STYLE_OFF = 8'h3f;
    localparam logic [7:0] SA_PA_DLY0_OFF = 8'h40;
    localparam logic [7:0] SA_PA_DLY1_OFF = 8'h41;
    localparam logic [7:0] SA_PA_DLY2_OFF = 8'h42;
    localparam logic [7:0] SA_PB_RATE_OFF = 8'h43;
    localparam logic [7:0] SA_PB_STYLE_OFF = 8'h44;
    localparam logic [7:0] SA_PB_DLY0_OFF = 8'h45;
    localparam logic [7:0] SA_PB_DLY1_OFF = 8'h46;
    localparam logic [7:0] SA_PB_DLY2_OFF = 8'h47;
    localparam logic [7:0] SB_ENABLE_OFF = 8'h48;
    localparam logic [7:0] SB_RUN_OFF = 8'h49;

    // ==========================================================
    // Field widths
    localparam int PRI_W = 4;
    localparam int MULT_HI_W = 6;
    localparam int DLY_HI_W = 6;

    // ==========================================================
    // Reset values, one per offset from BASE_OFF upward
    localparam logic [7:0] RST_TABLE [0:NUM_REGS-1] = '{
        8'h00, 8'h10, 8'h32, 8'h54, 8'h76, 8'h04, 8'h03,
        8'h00, 8'h04, 8'h02, 8'h00, 8'h3c, 8'h00,
        8'h00, 8'h10, 8'h32, 8'h54, 8'h76, 8'h04,
        8'h8f, 8'h0f, 8'h00, 8'h01, 8'h00, 8'h3e, 8'h00, 8'h00,
        8'h05, 8'h83, 8'h00, 8'h00, 8'h00,
        8'h05, 8'h11, 8'h00, 8'h00, 8'h00,
        8'h83, 8'h03
    };

endpackage : lsc_pkg

// ### common/lsc_reg_if.sv
// Purpose: Write path from the host port decoder to the register cells.
// Assumes: Single clock, write strobe is one cycle per access.
// Notes:   The top drives it, every read/write cell listens; status cells do not.

interface lsc_reg_if;
    logic wr_en;
    logic [7:0] addr;
    logic [7:0] wdata;

    modport drive (output wr_en, output addr, output wdata);
    modport sink (input wr_en, input addr, input wdata);
endinterface : lsc_reg_if

// ### hw/lsc_cfg_reg.sv
// Purpose: One 8-bit read/write configuration register cell.
// Assumes: Write is taken on the clock edge where strobe and address match.
// Notes:   Value appears on the next cycle.

module lsc_cfg_reg #(
    parameter logic [7:0] ADDR = 8'h00,
    parameter logic [7:0] RESET = 8'h00
) (
    // Clock and reset
    input logic clk_sys,
    input logic resetn,
    // Write path
    lsc_reg_if.sink bus,
    // Stored value
    output logic [7:0] value
);

    typedef struct packed {
        logic [7:0] value;
    } lsc_cfg_state_t;

    lsc_cfg_state_t st_q;
    lsc_cfg_state_t st_d;

    always_comb begin
        st_d = st_q;
        if (bus.wr_en && (bus.addr == ADDR)) begin
            st_d.value = bus.wdata;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            st_q <= RESET;
        end else begin
            st_q <= st_d;
        end
    end

    assign value = st_q.value;

endmodule : lsc_cfg_reg

// ### hw/lsc_status_reg.sv
// Purpose: Read-only status register sampling a live state from the loop.
// Assumes: Live input is synchronous to clk_sys.
// Notes:   Has no write path at all.

module lsc_status_reg #(
    parameter logic [7:0] RESET = 8'h00
) (
    // Clock and reset
    input logic clk_sys,
    input logic resetn,
    // Live state
    input logic [7:0] live,
    // Sampled value
    output logic [7:0] value
);

    typedef struct packed {
        logic [7:0] value;
    } lsc_stat_state_t;

    lsc_stat_state_t st_q;
    lsc_stat_state_t st_d;

    always_comb begin
        st_d = st_q;
        st_d.value = live;
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            st_q <= RESET;
        end else begin
            st_q <= st_d;
        end
    end

    assign value = st_q.value;

endmodule : lsc_status_reg

// ### hw/lsc_config_regs.sv
// Purpose: Loop and synthesizer configuration/status register bank.
// Assumes: Serial host port already deserialised into address/strobe form.
// Notes:   Reads answer one cycle after the read strobe.
//
// Summary of operation
// - Per-reference priority nibbles, reset to index
// - Revertive enables per loop, reset zero
// - Primary loop lock status readable, reset 04
// - Secondary loop lock status at 35
// - Secondary control A, reset 00
// - Secondary control B, reset 04
// - Secondary mode select at 2C, reset 02
// - Reference choice: control or current selection
// - Four failure masks, reset 3C
// - Restore delay register, reset 00
// - Synth A enables and source, reset 8F
// - Synth A run controls, reset 0F
// - Synth A 14-bit N over two registers
// - Two coarse phase controls, reset 00
// - Synth A clock B divider, reset 3E
// - Synth A fine phase, reset 00
// - Pulse rate selects, reset 05
// - Pulse styles reset 83 and 11
// - Pulse A delay 22 bits, three registers
// - Pulse B delay same 22-bit layout
// - Synth B enables 83, run 03

module lsc_config_regs (
    // Clock and reset
    input logic clk_sys,
    input logic resetn,
    // Host register port
    input logic [7:0] host_addr,
    input logic host_wr,
    input logic [7:0] host_wdata,
    input logic host_rd,
    output logic [7:0] host_rdata,
    output logic host_rvalid,
    // Live loop state
    input logic [7:0] loop1_lock_state_in,
    input logic [7:0] loop2_lock_state_in,
    input logic loop2_refsel_report_en,
    input logic [7:0] loop2_refsel_status_in,
    // Primary loop controls
    output logic [7:0] loop1_revertive_enables,
    output logic [31:0] loop1_ref_priority,
    // Secondary loop controls
    output logic [7:0] loop2_control_a,
    output logic [7:0] loop2_control_b,
    output logic [7:0] loop2_mode_select,
    output logic [7:0] loop2_reference_choice,
    output logic [7:0] loop2_failure_masks,
    output logic [7:0] loop2_restore_delay,
    output logic [7:0] loop2_revertive_enables,
    output logic [31:0] loop2_ref_priority,
    // Synth A controls
    output logic [7:0] synth_a_output_enables,
    output logic [7:0] synth_a_output_run,
    output logic [13:0] synth_a_multiplier,
    output logic [7:0] synth_a_clock_a_coarse_phase,
    output logic [7:0] synth_a_clock_b_divider,
    output logic [7:0] synth_a_clock_b_coarse_phase,
    output logic [7:0] synth_a_fine_phase,
    output logic [7:0] synth_a_pulse_a_rate,
    output logic [7:0] synth_a_pulse_a_style,
    output logic [21:0] synth_a_pulse_a_delay,
    output logic [7:0] synth_a_pulse_b_rate,
    output logic [7:0] synth_a_pulse_b_style,
    output logic [21:0] synth_a_pulse_b_delay,
    // Synth B controls
    output logic [7:0] synth_b_output_enables,
    output logic [7:0] synth_b_output_run
);

    // ==========================================================
    // Index of each register within the bank
    localparam int I_L1_REV = int'(lsc_pkg::LOOP1_REV_OFF - lsc_pkg::BASE_OFF);
    localparam int I_L1_P0 = int'(lsc_pkg::LOOP1_PRI0_OFF - lsc_pkg::BASE_OFF);
    localparam int I_L1_P1 = int'(lsc_pkg::LOOP1_PRI1_OFF - lsc_pkg::BASE_OFF);
    localparam int I_L1_P2 = int'(lsc_pkg::LOOP1_PRI2_OFF - lsc_pkg::BASE_OFF);
    localparam int I_L1_P3 = int'(lsc_pkg::LOOP1_PRI3_OFF - lsc_pkg::BASE_OFF);
    localparam int I_L1_LOCK = int'(lsc_pkg::LOOP1_LOCK_OFF - lsc_pkg::BASE_OFF);
    localparam int I_L2_CA = int'(lsc_pkg::LOOP2_CTRL_A_OFF - lsc_pkg::BASE_OFF);
    localparam int I_L2_CB = int'(lsc_pkg::LOOP2_CTRL_B_OFF - lsc_pkg::BASE_OFF);
    localparam int I_L2_MODE = int'(lsc_pkg::LOOP2_MODE_OFF - lsc_pkg::BASE_OFF);
    localparam int I_L2_SEL = int'(lsc_pkg::LOOP2_REFSEL_OFF - lsc_pkg::BASE_OFF);
    localparam int I_L2_MASK = int'(lsc_pkg::LOOP2_FAIL_MASK_OFF - lsc_pkg::BASE_OFF);
    localparam int I_L2_RST = int'(lsc_pkg::LOOP2_RESTORE_OFF - lsc_pkg::BASE_OFF);
    localparam int I_L2_REV = int'(lsc_pkg::LOOP2_REV_OFF - lsc_pkg::BASE_OFF);
    localparam int I_L2_P0 = int'(lsc_pkg::LOOP2_PRI0_OFF - lsc_pkg::BASE_OFF);
    localparam int I_L2_P1 = int'(lsc_pkg::LOOP2_PRI1_OFF - lsc_pkg::BASE_OFF);
    localparam int I_L2_P2 = int'(lsc_pkg::LOOP2_PRI2_OFF - lsc_pkg::BASE_OFF);
    localparam int I_L2_P3 = int'(lsc_pkg::LOOP2_PRI3_OFF - lsc_pkg::BASE_OFF);
    localparam int I_L2_LOCK = int'(lsc_pkg::LOOP2_LOCK_OFF - lsc_pkg::BASE_OFF);
    localparam int I_SA_EN = int'(lsc_pkg::SA_ENABLE_OFF - lsc_pkg::BASE_OFF);
    localparam int I_SA_RUN = int'(lsc_pkg::SA_RUN_OFF - lsc_pkg::BASE_OFF);
    localparam int I_SA_NLO = int'(lsc_pkg::SA_MULT_LO_OFF - lsc_pkg::BASE_OFF);
    localparam int I_SA_NHI = int'(lsc_pkg::SA_MULT_HI_OFF - lsc_pkg::BASE_OFF);
    localparam int I_SA_CAP = int'(lsc_pkg::SA_CLKA_PHASE_OFF - lsc_pkg::BASE_OFF);
    localparam int I_SA_CBD = int'(lsc_pkg::SA_CLKB_DIV_OFF - lsc_pkg::BASE_OFF);
    localparam int I_SA_CBP = int'(lsc_pkg::SA_CLKB_PHASE_OFF - lsc_pkg::BASE_OFF);
    localparam int I_SA_FINE = int'(lsc_pkg::SA_FINE_OFF - lsc_pkg::BASE_OFF);
    localparam int I_PA_RATE = int'(lsc_pkg::SA_PA_RATE_OFF - lsc_pkg::BASE_OFF);
    localparam int I_PA_STY = int'(lsc_pkg::SA_PA_STYLE_OFF - lsc_pkg::BASE_OFF);
    localparam int I_PA_D0 = int'(lsc_pkg::SA_PA_DLY0_OFF - lsc_pkg::BASE_OFF);
    localparam int I_PA_D1 = int'(lsc_pkg::SA_PA_DLY1_OFF - lsc_pkg::BASE_OFF);
    localparam int I_PA_D2 = int'(lsc_pkg::SA_PA_DLY2_OFF - lsc_pkg::BASE_OFF);
    localparam int I_PB_RATE = int'(lsc_pkg::SA_PB_RATE_OFF - lsc_pkg::BASE_OFF);
    localparam int I_PB_STY = int'(lsc_pkg::SA_PB_STYLE_OFF - lsc_pkg::BASE_OFF);
    localparam int I_PB_D0 = int'(lsc_pkg::SA_PB_DLY0_OFF - lsc_pkg::BASE_OFF);
    localparam int I_PB_D1 = int'(lsc_pkg::SA_PB_DLY1_OFF - lsc_pkg::BASE_OFF);
    localparam int I_PB_D2 = int'(lsc_pkg::SA_PB_DLY2_OFF - lsc_pkg::BASE_OFF);
    localparam int I_SB_EN = int'(lsc_pkg::SB_ENABLE_OFF - lsc_pkg::BASE_OFF);
    localparam int I_SB_RUN = int'(lsc_pkg::SB_RUN_OFF - lsc_pkg::BASE_OFF);

    // ==========================================================
    // Read port state
    typedef struct packed {
        logic [7:0] rdata;
        logic rvalid;
    } lsc_top_state_t;

    lsc_top_state_t st_q;
    lsc_top_state_t st_d;

    logic [7:0] bank_q [0:lsc_pkg::NUM_REGS-1];
    logic [7:0] rel_addr;
    logic in_range;

    lsc_reg_if wbus ();

    // ==========================================================
    // Write path to the cells
    assign wbus.wr_en = host_wr;
    assign wbus.addr = host_addr;
    assign wbus.wdata = host_wdata;

    // ==========================================================
    // Register cells
    for (genvar i = 0; i < lsc_pkg::NUM_REGS; i++) begin : g_cell
        if (i == I_L1_LOCK || i == I_L2_LOCK) begin : g_stat
            lsc_status_reg #(
                .RESET(lsc_pkg::RST_TABLE[i])
            ) u_stat (
                .clk_sys(clk_sys),
                .resetn(resetn),
                .live(i == I_L1_LOCK ? loop1_lock_state_in : loop2_lock_state_in),
                .value(bank_q[i])
            );
        end else begin : g_rw
            lsc_cfg_reg #(
                .ADDR(8'(int'(lsc_pkg::BASE_OFF) + i)),
                .RESET(lsc_pkg::RST_TABLE[i])
            ) u_cfg (
                .clk_sys(clk_sys),
                .resetn(resetn),
                .bus(wbus),
                .value(bank_q[i])
            );
        end
    end

    // ==========================================================
    // Read decode
    assign rel_addr = host_addr - lsc_pkg::BASE_OFF;
    assign in_range = (host_addr >= lsc_pkg::BASE_OFF) && (host_addr <= lsc_pkg::LAST_OFF);

    always_comb begin
        st_d = st_q;
        st_d.rvalid = host_rd;
        if (host_rd) begin
            if (!in_range) begin
                st_d.rdata = lsc_pkg::UNMAPPED_DATA;
            end else if (host_addr == lsc_pkg::LOOP2_REFSEL_OFF && loop2_refsel_report_en) begin
                st_d.rdata = loop2_refsel_status_in;
            end else begin
                st_d.rdata = bank_q[rel_addr[5:0]];
            end
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign host_rdata = st_q.rdata;
    assign host_rvalid = st_q.rvalid;

    // ==========================================================
    // Primary loop outputs
    // revertive enables
    assign loop1_revertive_enables = bank_q[I_L1_REV];
    assign loop1_ref_priority = {bank_q[I_L1_P3], bank_q[I_L1_P2],
                                 bank_q[I_L1_P1], bank_q[I_L1_P0]};

    // ==========================================================
    // Secondary loop outputs
    // control A
    assign loop2_control_a = bank_q[I_L2_CA];
    assign loop2_control_b = bank_q[I_L2_CB];
    assign loop2_mode_select = bank_q[I_L2_MODE];
    assign loop2_reference_choice = bank_q[I_L2_SEL];
    assign loop2_failure_masks = bank_q[I_L2_MASK];
    assign loop2_restore_delay = bank_q[I_L2_RST];
    assign loop2_revertive_enables = bank_q[I_L2_REV];
    assign loop2_ref_priority = {bank_q[I_L2_P3], bank_q[I_L2_P2],
                                 bank_q[I_L2_P1], bank_q[I_L2_P0]};

    // ==========================================================
    // Synth A outputs
    // enables and source
    assign synth_a_output_enables = bank_q[I_SA_EN];
    assign synth_a_output_run = bank_q[I_SA_RUN];
    assign synth_a_multiplier = {bank_q[I_SA_NHI][lsc_pkg::MULT_HI_W-1:0],
                                 bank_q[I_SA_NLO]};
    assign synth_a_clock_a_coarse_phase = bank_q[I_SA_CAP];
    assign synth_a_clock_b_coarse_phase = bank_q[I_SA_CBP];
    assign synth_a_clock_b_divider = bank_q[I_SA_CBD];
    assign synth_a_fine_phase = bank_q[I_SA_FINE];
    assign synth_a_pulse_a_rate = bank_q[I_PA_RATE];
    assign synth_a_pulse_b_rate = bank_q[I_PB_RATE];
    assign synth_a_pulse_a_style = bank_q[I_PA_STY];
    assign synth_a_pulse_b_style = bank_q[I_PB_STY];
    assign synth_a_pulse_a_delay = {bank_q[I_PA_D2][lsc_pkg::DLY_HI_W-1:0],
                                    bank_q[I_PA_D1], bank_q[I_PA_D0]};
    assign synth_a_pulse_b_delay = {bank_q[I_PB_D2][lsc_pkg::DLY_HI_W-1:0],
                                    bank_q[I_PB_D1], bank_q[I_PB_D0]};

    // ==========================================================
    // Synth B outputs
    // enables and run
    assign synth_b_output_enables = bank_q[I_SB_EN];
    assign synth_b_output_run = bank_q[I_SB_RUN];

endmodule : lsc_config_regs

// ### tb/lsc_cfg_assertions.sv
// Purpose: Port-level checks for the configuration register bank.
// Assumes: Sees only the ports of lsc_config_regs.
// Notes:   Bound at the foot of this file.

module lsc_cfg_assertions (
    // Clock and reset
    input logic clk_sys,
    input logic resetn,
    // Host port
    input logic [7:0] host_addr,
    input logic host_wr,
    input logic [7:0] host_wdata,
    input logic host_rd,
    input logic [7:0] host_rdata,
    input logic host_rvalid,
    // Watched state
    input logic [7:0] loop1_lock_state_in,
    input logic [7:0] loop2_lock_state_in,
    input logic [31:0] loop1_ref_priority,
    input logic [31:0] loop2_ref_priority,
    input logic [7:0] loop2_mode_select,
    input logic [7:0] loop2_failure_masks,
    input logic [7:0] loop2_revertive_enables,
    input logic [13:0] synth_a_multiplier,
    input logic [21:0] synth_a_pulse_a_delay,
    input logic [21:0] synth_a_pulse_b_delay
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    // ==========================================
    // Read port
    property p_rd_answer; host_rd |=> host_rvalid; endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
    property p_no_spurious; !host_rd |=> !host_rvalid; endproperty
    a_no_spurious: assert property (p_no_spurious) else $error("stray answer");
    property p_oob; host_rd && (host_addr < 8'h23 || host_addr > 8'h49) |=> host_rdata == 8'h00;
    endproperty
    a_oob: assert property (p_oob) else $error("unmapped read not zero");
    property p_stat1; host_rd && host_addr == 8'h28 |=>
        !$past(resetn, 2) || host_rdata == $past(loop1_lock_state_in, 2); endproperty
    a_stat1: assert property (p_stat1) else $error("primary status wrong");
    property p_stat2; host_rd && host_addr == 8'h35 |=>
        !$past(resetn, 2) || host_rdata == $past(loop2_lock_state_in, 2); endproperty
    a_stat2: assert property (p_stat2) else $error("secondary status wrong");

    // ==========================================
    // Stored fields
    property p_pri_reset; $rose(resetn) |->
        loop1_ref_priority == 32'h76543210 && loop2_ref_priority == 32'h76543210; endproperty
    a_pri_reset: assert property (p_pri_reset) else $error("priority reset wrong");
    property p_mode; host_wr && host_addr == 8'h2c |=> loop2_mode_select == $past(host_wdata);
    endproperty
    a_mode: assert property (p_mode) else $error("mode write lost");
    property p_rev2; host_wr && host_addr == 8'h30 |=>
        loop2_revertive_enables == $past(host_wdata); endproperty
    a_rev2: assert property (p_rev2) else $error("revertive write lost");
    property p_mask; !(host_wr && host_addr == 8'h2e) |=> $stable(loop2_failure_masks);
    endproperty
    a_mask: assert property (p_mask) else $error("mask changed unasked");
    property p_mult; host_wr && host_addr == 8'h39 |=>
        synth_a_multiplier[13:8] == $past(host_wdata[5:0]); endproperty
    a_mult: assert property (p_mult) else $error("multiplier high wrong");
    property p_dly_a; host_wr && host_addr == 8'h42 |=>
        synth_a_pulse_a_delay[21:16] == $past(host_wdata[5:0]); endproperty
    a_dly_a: assert property (p_dly_a) else $error("pulse a delay wrong");
    property p_dly_b; host_wr && host_addr == 8'h46 |=>
        synth_a_pulse_b_delay[15:8] == $past(host_wdata); endproperty
    a_dly_b: assert property (p_dly_b) else $error("pulse b delay wrong");

    // ==========================================
    // Coverage
    c_stat: cover property (host_rd && host_addr == 8'h28);
    c_mult: cover property (host_wr && host_addr == 8'h39);
    c_oob: cover property (host_rd && host_addr > 8'h49);
endmodule : lsc_cfg_assertions

bind lsc_config_regs lsc_cfg_assertions chk_u (.clk_sys, .resetn, .host_addr, .host_wr,
    .host_wdata, .host_rd, .host_rdata, .host_rvalid, .loop1_lock_state_in,
    .loop2_lock_state_in, .loop1_ref_priority, .loop2_ref_priority, .loop2_mode_select,
    .loop2_failure_masks, .loop2_revertive_enables, .synth_a_multiplier,
    .synth_a_pulse_a_delay, .synth_a_pulse_b_delay);

// ### tb/lsc_host_model.sv
// Purpose: Host software seen through the parallel register port.
// Assumes: One strobe per access, one idle cycle between accesses.
// Notes:   Released data lines carry the inverse of the last value.

module lsc_host_model (
    // Clock
    input logic clk_sys,
    // Register port
    output logic [7:0] host_addr,
    output logic host_wr,
    output logic [7:0] host_wdata,
    output logic host_rd
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        host_addr = 8'h00;
        host_wr = 1'b0;
        host_wdata = 8'h00;
        host_rd = 1'b0;
    end

    // ==========================================
    // Accesses
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        host_wr <= 1'b1;
        host_addr <= a;
        host_wdata <= d;
        @(posedge clk_sys);
        host_wr <= 1'b0;
        host_wdata <= ~d;
    endtask : write_reg

    task automatic read_reg(input logic [7:0] a);
        @(posedge clk_sys);
        host_rd <= 1'b1;
        host_addr <= a;
        @(posedge clk_sys);
        host_rd <= 1'b0;
        host_addr <= ~a;
    endtask : read_reg
endmodule : lsc_host_model

// ### tb/tb_top.sv
// Purpose: Self-checking bench for the configuration register bank.
// Assumes: Reads are answered one cycle after the strobe.
// Notes:   Expected read data is queued, a monitor compares answers.

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [7:0] RST_EXP [0:38] = '{
        8'h00, 8'h10, 8'h32, 8'h54, 8'h76, 8'h04, 8'h03, 8'h00, 8'h04, 8'h02,
        8'h00, 8'h3c, 8'h00, 8'h00, 8'h10, 8'h32, 8'h54, 8'h76, 8'h04, 8'h8f,
        8'h0f, 8'h00, 8'h01, 8'h00, 8'h3e, 8'h00, 8'h00, 8'h05, 8'h83, 8'h00,
        8'h00, 8'h00, 8'h05, 8'h11, 8'h00, 8'h00, 8'h00, 8'h83, 8'h03};

    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] host_addr, host_wdata, host_rdata;
    logic host_wr, host_rd, host_rvalid, loop2_refsel_report_en = 1'b0;
    logic [7:0] loop1_lock_state_in = 8'h04, loop2_lock_state_in = 8'h04;
    logic [7:0] loop2_refsel_status_in = 8'h00;
    logic [7:0] loop1_revertive_enables, loop2_control_a, loop2_control_b, loop2_mode_select;
    logic [7:0] loop2_reference_choice, loop2_failure_masks, loop2_restore_delay;
    logic [7:0] loop2_revertive_enables, synth_a_output_enables, synth_a_output_run;
    logic [7:0] synth_a_clock_a_coarse_phase, synth_a_clock_b_divider, synth_a_fine_phase;
    logic [7:0] synth_a_clock_b_coarse_phase, synth_a_pulse_a_rate, synth_a_pulse_a_style;
    logic [7:0] synth_a_pulse_b_rate, synth_a_pulse_b_style;
    logic [7:0] synth_b_output_enables, synth_b_output_run;
    logic [31:0] loop1_ref_priority, loop2_ref_priority;
    logic [13:0] synth_a_multiplier;
    logic [21:0] synth_a_pulse_a_delay, synth_a_pulse_b_delay;
    logic [7:0] mem [0:38];
    logic [7:0] exp_q [$];
    logic [7:0] d;
    int seed = 32'h1bbf;
    int miscompares = 0;
    int checks_done = 0;

    always #4 clk_sys = ~clk_sys;

    lsc_config_regs dut_u (.*);
    lsc_host_model host_u (.clk_sys(clk_sys), .host_addr(host_addr), .host_wr(host_wr),
        .host_wdata(host_wdata), .host_rd(host_rd));

    // ==========================================
    // Compare and report
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic wrap_up();
        $display("checks=%0d mismatches=%0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : wrap_up

    always @(negedge clk_sys) begin
        if (host_rvalid === 1'b1) begin
            if (exp_q.size() == 0) begin
                check({24'h0, host_rdata}, 32'h1ff);
            end else begin
                check({24'h0, host_rdata}, {24'h0, exp_q.pop_front()});
            end
        end
    end

    // ==========================================
    // Helpers
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        host_u.read_reg(a);
    endtask : rd

    task automatic do_reset();
        resetn <= 1'b0;
        loop1_lock_state_in <= 8'h04;
        loop2_lock_state_in <= 8'h04;
        repeat (6) @(posedge clk_sys);
        resetn <= 1'b1;
        for (int i = 0; i < 39; i++) mem[i] = RST_EXP[i];
    endtask : do_reset

    task automatic sweep_and_fields();
        for (int i = 0; i < 39; i++) rd(8'h23 + i[7:0], mem[i]);
        @(posedge clk_sys);
        check(loop1_ref_priority, {mem[4], mem[3], mem[2], mem[1]});
        check(loop2_ref_priority, {mem[17], mem[16], mem[15], mem[14]});
        check({18'h0, synth_a_multiplier}, {18'h0, mem[22][5:0], mem[21]});
        check({10'h0, synth_a_pulse_a_delay}, {10'h0, mem[31][5:0], mem[30], mem[29]});
        check({10'h0, synth_a_pulse_b_delay}, {10'h0, mem[36][5:0], mem[35], mem[34]});
        check({24'h0, loop2_reference_choice}, {24'h0, mem[10]});
        check({24'h0, synth_a_output_enables}, {24'h0, mem[19]});
        check({24'h0, synth_b_output_run}, {24'h0, mem[38]});
        check({loop1_revertive_enables, loop2_control_a, loop2_control_b, loop2_restore_delay},
              {mem[0], mem[7], mem[8], mem[12]});
        check({synth_a_output_run, synth_a_clock_a_coarse_phase, synth_a_clock_b_coarse_phase,
               synth_a_clock_b_divider},
              {mem[20], mem[23], mem[25], mem[24]});
        check({synth_a_fine_phase, synth_a_pulse_a_rate, synth_a_pulse_a_style,
               synth_a_pulse_b_rate},
              {mem[26], mem[27], mem[28], mem[32]});
        check({synth_a_pulse_b_style, synth_b_output_enables, loop2_mode_select,
               loop2_failure_masks},
              {mem[33], mem[37], mem[9], mem[11]});
    endtask : sweep_and_fields

    // ==========================================
    // Main sequence
    initial begin
        do_reset();
        sweep_and_fields();
        $display("test reset_values done");
        for (int i = 0; i < 39; i++) begin
            d = 8'($random(seed));
            host_u.write_reg(8'h23 + i[7:0], d);
            if (i != 5 && i != 18) mem[i] = d;
        end
        sweep_and_fields();
        $display("test write_readback done");
        @(posedge clk_sys);
        loop1_lock_state_in <= 8'($random(seed));
        loop2_lock_state_in <= 8'($random(seed));
        loop2_refsel_status_in <= 8'($random(seed));
        loop2_refsel_report_en <= 1'b1;
        @(posedge clk_sys);
        rd(8'h28, loop1_lock_state_in);
        rd(8'h35, loop2_lock_state_in);
        rd(8'h2d, loop2_refsel_status_in);
        loop2_refsel_report_en <= 1'b0;
        rd(8'h2d, mem[10]);
        mem[5] = loop1_lock_state_in;
        mem[18] = loop2_lock_state_in;
        $display("test status_and_selection done");
        host_u.write_reg(8'h4a, 8'hff);
        host_u.write_reg(8'h22, 8'hff);
        rd(8'h22, 8'h00);
        rd(8'h4a, 8'h00);
        rd(8'hff, 8'h00);
        sweep_and_fields();
        $display("test unmapped done");
        @(posedge clk_sys);
        do_reset();
        sweep_and_fields();
        $display("test mid_run_reset done");
        repeat (4) @(posedge clk_sys);
        check(exp_q.size(), 0);
        wrap_up();
    end

    initial begin
        repeat (5000) @(posedge clk_sys);
        miscompares++;
        $display("watchdog expired");
        wrap_up();
    end
endmodule : tb_top
